//--- common/sc_timing_pkg.sv
// Register map, field layout and constants of the card timing and interrupt block
package sc_timing_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_EXTRA_GUARD_TIME = 8'h0c;
    localparam logic [7:0] OFS_RX_IDLE_TIMEOUT = 8'h10;
    localparam logic [7:0] OFS_ELEM_UNIT_CONTROL = 8'h14;
    localparam logic [7:0] OFS_IRQ_ENABLE_MASK = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
    localparam logic [7:0] OFS_SEQ_CONTROL = 8'h20;

    // Field widths
    localparam int GUARD_W = 8;
    localparam int LIMIT_W = 9;
    localparam int DIV_W = 12;
    localparam int NUM_IRQ = 11;
    localparam int NUM_SEQ = 3;

    // Reset values
    localparam logic [GUARD_W-1:0] GUARD_RESET = 8'h00;
    localparam logic [LIMIT_W-1:0] LIMIT_RESET = 9'h000;
    localparam logic [DIV_W-1:0] DIV_RESET = 12'h173;
    localparam logic [NUM_IRQ-1:0] MASK_RESET = 11'h000;

    // Interrupt source positions, shared by status and mask
    localparam int IRQ_RX_AVAIL = 0;
    localparam int IRQ_TX_EMPTY = 1;
    localparam int IRQ_XFER_ERROR = 2;
    localparam int IRQ_TIMER_ZERO = 3;
    localparam int IRQ_TIMER_ONE = 4;
    localparam int IRQ_TIMER_TWO = 5;
    localparam int IRQ_BLOCK_GUARD = 6;
    localparam int IRQ_CARD_DETECT = 7;
    localparam int IRQ_SEQ_DONE = 8;
    localparam int IRQ_RX_IDLE = 9;
    localparam int IRQ_CONV_ERR = 10;

    // Sequence start bits in the sequence control register
    localparam int SEQ_POWER_DOWN = 0;
    localparam int SEQ_POWER_UP = 1;
    localparam int SEQ_SOFT_RESTART = 2;

    // Read-only card pin level in the status register
    localparam int STS_PIN_STATE = 16;

    // AHB transfer type bit that marks an active transfer
    localparam int HTRANS_ACTIVE_BIT = 1;

endpackage : sc_timing_pkg

//--- common/irq_bus_if.sv
// Carrier between the register block and the interrupt status collector
interface irq_bus_if #(parameter int N = 11);
    logic [N-1:0] event_set;
    logic [N-1:0] clear_ones;
    logic [N-1:0] enable_mask;
    logic [N-1:0] status;
    logic irq;

    modport ctrl (output event_set, output clear_ones, output enable_mask,
        input status, input irq);
    modport collect (input event_set, input clear_ones, input enable_mask,
        output status, output irq);
endinterface : irq_bus_if

//--- hw/irq_status.sv
// Sticky interrupt status flags with write-one-to-clear and masked level output
module irq_status
    import sc_timing_pkg::*;
#(
    parameter int N = NUM_IRQ
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Flags and mask
    irq_bus_if.collect bus
);

    wire logic [N-1:0] flags;
    logic irq_q;
    wire logic [N-1:0] pending;

    if (N < 1) begin : g_bad_n
        $error("irq_status needs at least one source");
    end

    for (genvar i = 0; i < N; i++) begin : g_flag
        // One flop per source, so each bit has a single driving process
        logic flag_q;

        // A new event beats a clear in the same cycle
        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                flag_q <= 1'b0;
            end else if (bus.event_set[i]) begin
                flag_q <= 1'b1;
            end else if (bus.clear_ones[i]) begin
                flag_q <= 1'b0;
            end
        end

        assign flags[i] = flag_q;
    end

    assign pending = flags & bus.enable_mask;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |pending;
        end
    end

    assign bus.status = flags;
    assign bus.irq = irq_q;

endmodule : irq_status

//--- hw/sc_timing_top.sv
// Card interface timing: unit divider, guard spacing, receive idle timeout, interrupts
// Function
// - Eight-bit extra guard time spaces transmitted characters
// - Idle counter reloads on every received character
// - Counter reaching one sets the idle flag
// - Idle interrupt only when flag and bit 9
// - Idle interval is limit plus half unit
// - Idle limit of zero disables the timeout
// - Unit lasts divider plus one clocks
// - Bit 10 gates convention error interrupt
// - Bit 8 gates sequence completion interrupt
// - Card insert or removal raises detect event
// - Bit 6 gates receive block guard interrupt
// - Bit 5 gates timer two interrupt
// - Finished sequence clears start bit, sets done
//
// Design decision made here: the AHB-Lite register port.
module sc_timing_top
    import sc_timing_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [ADDR_W-1:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Receive path
    input wire logic rx_char_in,
    input wire logic rx_byte_read_in,
    // Transmit path
    input wire logic tx_char_done_in,
    output logic tx_guard_hold_out,
    // Sequencer
    output logic [NUM_SEQ-1:0] seq_go_out,
    input wire logic [NUM_SEQ-1:0] seq_finish_in,
    // Other interrupt sources, one-cycle pulses
    input wire logic rx_avail_event_in,
    input wire logic tx_empty_event_in,
    input wire logic xfer_error_event_in,
    input wire logic [2:0] timer_event_in,
    input wire logic block_guard_rx_event_in,
    input wire logic conv_err_event_in,
    // Card detect pin
    input wire logic card_detect_pin_in,
    // Timing and interrupt
    output logic etu_tick_out,
    output logic irq_out
);

    if (ADDR_W < 6) begin : g_bad_addr
        $error("sc_timing_top needs at least 6 address bits");
    end

    irq_bus_if #(.N(NUM_IRQ)) irq_bus ();

    // ---------------- AHB-Lite slave ----------------
    logic wr_pend_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [31:0] rdata_q;
    wire logic addr_phase;
    wire logic rd_take;
    wire logic wr_take;
    wire logic [31:0] rd_mux;
    wire logic [31:0] wdata;

    assign addr_phase = hsel_in && hready_in && htrans_in[HTRANS_ACTIVE_BIT];
    assign rd_take = addr_phase && !hwrite_in;
    assign wr_take = addr_phase && hwrite_in;
    assign wdata = hwdata_in;

    // Zero wait states; every access, mapped or not, ends OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = rdata_q;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else begin
            wr_pend_q <= wr_take;
            wr_addr_q <= haddr_in;
        end
    end

    // Write strobes, decoded from the latched address in the data phase
    wire logic wr_guard;
    wire logic wr_limit;
    wire logic wr_div;
    wire logic wr_mask;
    wire logic wr_status;
    wire logic wr_seq;

    assign wr_guard = wr_pend_q && (wr_addr_q == ADDR_W'(OFS_EXTRA_GUARD_TIME));
    assign wr_limit = wr_pend_q && (wr_addr_q == ADDR_W'(OFS_RX_IDLE_TIMEOUT));
    assign wr_div = wr_pend_q && (wr_addr_q == ADDR_W'(OFS_ELEM_UNIT_CONTROL));
    assign wr_mask = wr_pend_q && (wr_addr_q == ADDR_W'(OFS_IRQ_ENABLE_MASK));
    assign wr_status = wr_pend_q && (wr_addr_q == ADDR_W'(OFS_IRQ_STATUS));
    assign wr_seq = wr_pend_q && (wr_addr_q == ADDR_W'(OFS_SEQ_CONTROL));

    // ---------------- Software registers ----------------
    logic [GUARD_W-1:0] extra_guard_count_q;
    logic [LIMIT_W-1:0] rx_idle_limit_q;
    logic [DIV_W-1:0] elem_unit_divider_q;
    logic [NUM_IRQ-1:0] irq_enable_mask_q;
    logic [NUM_SEQ-1:0] seq_go_q;
    logic [NUM_SEQ-1:0] seq_go_d;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            extra_guard_count_q <= GUARD_RESET;
            rx_idle_limit_q <= LIMIT_RESET;
            elem_unit_divider_q <= DIV_RESET;
            irq_enable_mask_q <= MASK_RESET;
        end else begin
            if (wr_guard) begin
                extra_guard_count_q <= wdata[GUARD_W-1:0];
            end
            if (wr_limit) begin
                rx_idle_limit_q <= wdata[LIMIT_W-1:0];
            end
            if (wr_div) begin
                // Values of four or less are the programmer's fault, not trapped
                elem_unit_divider_q <= wdata[DIV_W-1:0];
            end
            if (wr_mask) begin
                irq_enable_mask_q <= wdata[NUM_IRQ-1:0];
            end
        end
    end

    // Start bits: software sets, finishing sequence clears; a fresh start wins
    always_comb begin
        seq_go_d = seq_go_q & ~seq_finish_in;
        if (wr_seq) begin
            seq_go_d = seq_go_d | wdata[NUM_SEQ-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            seq_go_q <= '0;
        end else begin
            seq_go_q <= seq_go_d;
        end
    end

    assign seq_go_out = seq_go_q;

    // ---------------- Elementary time unit divider ----------------
    logic [DIV_W-1:0] etu_cnt_q;
    logic etu_tick_q;
    wire logic etu_end;

    assign etu_end = (etu_cnt_q >= elem_unit_divider_q);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            etu_cnt_q <= '0;
            etu_tick_q <= 1'b0;
        end else begin
            // Counts 0..divider, so one unit spans divider plus one clocks
            etu_cnt_q <= etu_end ? '0 : etu_cnt_q + 1'b1;
            etu_tick_q <= etu_end;
        end
    end

    assign etu_tick_out = etu_tick_q;

    // ---------------- Extra guard spacing ----------------
    logic [GUARD_W-1:0] guard_cnt_q;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            guard_cnt_q <= '0;
        end else if (tx_char_done_in) begin
            guard_cnt_q <= extra_guard_count_q;
        end else if (etu_tick_q && guard_cnt_q != '0) begin
            guard_cnt_q <= guard_cnt_q - 1'b1;
        end
    end

    // Transmitter waits while the extra guard units run out
    assign tx_guard_hold_out = (guard_cnt_q != '0);

    // ---------------- Receive idle timeout ----------------
    // Own cycle counter, restarted per character, so the half unit is exact
    localparam int SUB_W = DIV_W + 1;
    logic [SUB_W-1:0] sub_cnt_q;
    logic [LIMIT_W:0] idle_cnt_q;
    logic idle_armed_q;
    logic idle_event_q;
    wire logic [SUB_W-1:0] unit_len;
    wire logic [SUB_W-1:0] first_len;
    wire logic sub_end;
    wire logic idle_hit;

    assign unit_len = {1'b0, elem_unit_divider_q};
    // First step after one and a half units; later steps one unit each
    assign first_len = unit_len + SUB_W'(elem_unit_divider_q[DIV_W-1:1]) + 1'b1;
    assign sub_end = (sub_cnt_q == '0);
    assign idle_hit = idle_armed_q && sub_end && (idle_cnt_q == (LIMIT_W+1)'(2));

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sub_cnt_q <= '0;
            idle_cnt_q <= '0;
            idle_armed_q <= 1'b0;
            idle_event_q <= 1'b0;
        end else begin
            idle_event_q <= 1'b0;
            if (rx_char_in) begin
                // Limit of zero never arms the counter
                idle_armed_q <= (rx_idle_limit_q != '0);
                idle_cnt_q <= {1'b0, rx_idle_limit_q} + 1'b1;
                sub_cnt_q <= first_len;
            end else if (rx_byte_read_in || rx_idle_limit_q == '0) begin
                // A read, or a limit cleared mid-count, stops the timeout
                idle_armed_q <= 1'b0;
            end else if (idle_armed_q) begin
                if (sub_end) begin
                    sub_cnt_q <= unit_len;
                    idle_cnt_q <= idle_cnt_q - 1'b1;
                end else begin
                    sub_cnt_q <= sub_cnt_q - 1'b1;
                end
                if (idle_hit) begin
                    idle_armed_q <= 1'b0;
                    idle_event_q <= 1'b1;
                end
            end
        end
    end

    // ---------------- Card detect pin ----------------
    logic cd_meta_q;
    logic cd_sync_q;
    logic cd_last_q;
    logic cd_event_q;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cd_meta_q <= 1'b0;
            cd_sync_q <= 1'b0;
            cd_last_q <= 1'b0;
            cd_event_q <= 1'b0;
        end else begin
            cd_meta_q <= card_detect_pin_in;
            cd_sync_q <= cd_meta_q;
            cd_last_q <= cd_sync_q;
            // Both insertion and removal count as one detect event
            cd_event_q <= cd_sync_q ^ cd_last_q;
        end
    end

    wire logic card_detect_pin_state;
    assign card_detect_pin_state = cd_last_q;

    // ---------------- Interrupt sources ----------------
    wire logic [NUM_IRQ-1:0] events;

    assign events[IRQ_RX_AVAIL] = rx_avail_event_in;
    assign events[IRQ_TX_EMPTY] = tx_empty_event_in;
    assign events[IRQ_XFER_ERROR] = xfer_error_event_in;
    assign events[IRQ_TIMER_ZERO] = timer_event_in[0];
    assign events[IRQ_TIMER_ONE] = timer_event_in[1];
    assign events[IRQ_TIMER_TWO] = timer_event_in[2];
    assign events[IRQ_BLOCK_GUARD] = block_guard_rx_event_in;
    assign events[IRQ_CARD_DETECT] = cd_event_q;
    assign events[IRQ_SEQ_DONE] = |seq_finish_in;
    assign events[IRQ_RX_IDLE] = idle_event_q;
    assign events[IRQ_CONV_ERR] = conv_err_event_in;

    assign irq_bus.event_set = events;
    assign irq_bus.clear_ones = wr_status ? wdata[NUM_IRQ-1:0] : '0;
    assign irq_bus.enable_mask = irq_enable_mask_q;

    irq_status #(.N(NUM_IRQ)) u_irq_status (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .bus(irq_bus.collect)
    );

    assign irq_out = irq_bus.irq;

    // ---------------- Read data ----------------
    wire logic [31:0] status_word;
    wire logic [ADDR_W-1:0] ra;

    assign ra = haddr_in;
    assign status_word = {15'h0000, card_detect_pin_state, 5'h00, irq_bus.status};

    // Reserved bits and unmapped offsets read as zero
    assign rd_mux =
        (ra == ADDR_W'(OFS_EXTRA_GUARD_TIME)) ? {24'h00_0000, extra_guard_count_q} :
        (ra == ADDR_W'(OFS_RX_IDLE_TIMEOUT)) ? {23'h00_0000, rx_idle_limit_q} :
        (ra == ADDR_W'(OFS_ELEM_UNIT_CONTROL)) ? {20'h0_0000, elem_unit_divider_q} :
        (ra == ADDR_W'(OFS_IRQ_ENABLE_MASK)) ? {21'h00_0000, irq_enable_mask_q} :
        (ra == ADDR_W'(OFS_IRQ_STATUS)) ? status_word :
        (ra == ADDR_W'(OFS_SEQ_CONTROL)) ? {29'h0000_0000, seq_go_q} :
        32'h0000_0000;

    // Sampled in the address phase so data stands through the data phase
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_q <= '0;
        end else if (rd_take) begin
            rdata_q <= rd_mux;
        end
    end

endmodule : sc_timing_top

//--- testbench/sc_timing_props.sv
// Port-level concurrent checks for the card timing and interrupt block
module sc_timing_props
    import sc_timing_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Bus
    input wire logic hsel_in,
    input wire logic [ADDR_W-1:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    // Block side
    input wire logic tx_char_done_in,
    input wire logic tx_guard_hold_out,
    input wire logic [NUM_SEQ-1:0] seq_go_out,
    input wire logic [NUM_SEQ-1:0] seq_finish_in,
    input wire logic etu_tick_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_dp_q;
    logic rd_dp_q;
    logic [ADDR_W-1:0] rd_addr_q;
    wire logic take_w = hsel_in & hready_in & htrans_in[HTRANS_ACTIVE_BIT];
    wire logic [31:0] rsv_w = (rd_addr_q == OFS_EXTRA_GUARD_TIME) ? 32'hffff_ff00 :
        (rd_addr_q == OFS_RX_IDLE_TIMEOUT) ? 32'hffff_fe00 :
        (rd_addr_q == OFS_ELEM_UNIT_CONTROL) ? 32'hffff_f000 :
        (rd_addr_q == OFS_IRQ_ENABLE_MASK) ? 32'hffff_f800 : 32'h0000_0000;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    // Data phase tracking, mirrors the bus timing at the pins
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_dp_q <= 1'b0;
            rd_dp_q <= 1'b0;
            rd_addr_q <= '0;
        end else begin
            wr_dp_q <= take_w & hwrite_in;
            rd_dp_q <= take_w & ~hwrite_in;
            rd_addr_q <= haddr_in;
        end
    end

    // Divider is never below five; the check demands ticks at least five apart
    sequence s_tick_gap;
        !etu_tick_out [*4];
    endsequence

    a_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("bus answer not ready or not OKAY");
    a_reserved_zero: assert property (rd_dp_q |-> (hrdata_out & rsv_w) == 32'h0000_0000)
        else $error("reserved read bits not zero");
    a_tick_gap: assert property (etu_tick_out |=> s_tick_gap)
        else $error("unit ticks too close");
    a_guard_start: assert property ($rose(tx_guard_hold_out) |-> $past(tx_char_done_in))
        else $error("guard hold rose without a sent character");
    a_guard_end: assert property ($fell(tx_guard_hold_out) |->
        etu_tick_out || $past(etu_tick_out) || $past(etu_tick_out, 2))
        else $error("guard hold ended off a unit tick");
    a_irq_fall: assert property ($fell(irq_out) |->
        $past(wr_dp_q) || $past(wr_dp_q, 2))
        else $error("interrupt dropped without a register write");
    a_seq_set: assert property (|(seq_go_out & ~$past(seq_go_out)) |-> $past(wr_dp_q))
        else $error("sequence start without a write");
    a_seq_clear: assert property (|($past(seq_go_out) & ~seq_go_out) |->
        |($past(seq_go_out) & $past(seq_finish_in)))
        else $error("sequence start cleared without finish");
endmodule : sc_timing_props

bind sc_timing_top sc_timing_props #(.ADDR_W(ADDR_W)) u_props (.clk_in(clk_in),
    .resetn_in(resetn_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .tx_char_done_in(tx_char_done_in),
    .tx_guard_hold_out(tx_guard_hold_out), .seq_go_out(seq_go_out),
    .seq_finish_in(seq_finish_in), .etu_tick_out(etu_tick_out), .irq_out(irq_out));

//--- testbench/card_model.sv
// Behavioural card: received characters, detect pin, sequence completion
module card_model
    import sc_timing_pkg::*;
#(
    parameter int FINISH_DELAY = 10
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Sequencer handshake
    input wire logic [NUM_SEQ-1:0] seq_go_in,
    output logic [NUM_SEQ-1:0] seq_finish_out,
    // Card contacts
    output logic rx_char_out,
    output logic card_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_q;

    initial rx_char_out = 1'b0;
    initial card_pin_out = 1'b0;

    // Finish is a single pulse; the start bit drops on it
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wait_q <= 0;
            seq_finish_out <= '0;
        end else if (seq_finish_out != '0) begin
            seq_finish_out <= '0;
        end else if (|seq_go_in) begin
            wait_q <= (wait_q == FINISH_DELAY) ? 0 : wait_q + 1;
            seq_finish_out <= (wait_q == FINISH_DELAY) ? seq_go_in : '0;
        end
    end

    task send_char;
        @(posedge clk_in);
        rx_char_out <= 1'b1;
        @(posedge clk_in);
        rx_char_out <= 1'b0;
    endtask : send_char

    task set_pin(input logic v);
        @(posedge clk_in);
        card_pin_out <= v;
    endtask : set_pin
endmodule : card_model

//--- testbench/tb_sc_timing_top.sv
// Self-checking bench for the card timing and interrupt block
module tb_sc_timing_top
    import sc_timing_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic hsel_in = 1'b0;
    logic [7:0] haddr_in = '0;
    logic [1:0] htrans_in = '0;
    logic hwrite_in = 1'b0;
    logic [31:0] hwdata_in = '0;
    logic tx_char_done_in = 1'b0;
    logic rx_byte_read_in = 1'b0;
    logic [10:0] ev = '0;
    logic [31:0] hrdata_out;
    logic [2:0] seq_go;
    logic [2:0] seq_fin;
    logic hreadyout_out, hresp_out, rx_char, card_pin, tx_guard_hold_out, etu_tick_out, irq_out;
    int errors = 0;
    int checked = 0;
    int n;
    int s;
    logic [7:0] ofs[4] = '{OFS_EXTRA_GUARD_TIME, OFS_RX_IDLE_TIMEOUT, OFS_ELEM_UNIT_CONTROL,
        OFS_IRQ_ENABLE_MASK};
    logic [31:0] rst[4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0173, 32'h0000_0000};
    logic [31:0] full[4] = '{32'h0000_00ff, 32'h0000_01ff, 32'h0000_0fff, 32'h0000_07ff};
    int src[8] = '{0, 1, 2, 3, 4, 5, 6, 10};

    sc_timing_top u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .rx_char_in(rx_char),
        .rx_byte_read_in(rx_byte_read_in), .tx_char_done_in(tx_char_done_in),
        .tx_guard_hold_out(tx_guard_hold_out), .seq_go_out(seq_go), .seq_finish_in(seq_fin),
        .rx_avail_event_in(ev[0]), .tx_empty_event_in(ev[1]), .xfer_error_event_in(ev[2]),
        .timer_event_in(ev[5:3]), .block_guard_rx_event_in(ev[6]), .conv_err_event_in(ev[10]),
        .card_detect_pin_in(card_pin), .etu_tick_out(etu_tick_out), .irq_out(irq_out));
    card_model u_card (.clk_in(clk_in), .resetn_in(resetn_in), .seq_go_in(seq_go),
        .seq_finish_out(seq_fin), .rx_char_out(rx_char), .card_pin_out(card_pin));

    initial begin
        forever #20 clk_in = ~clk_in;
    end

    task results;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    task cmp32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp32

    task cmp1(input logic got, input logic exp);
        cmp32({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask : cmp1

    // Bounded wait on the interrupt line; a timeout ends the run
    task wait_irq(input logic exp);
        int k;
        for (k = 0; k < 40 && irq_out !== exp; k++) @(posedge clk_in);
        checked++;
        if (irq_out !== exp) begin
            errors++;
            $display("ERROR %0t: interrupt wait timed out", $time);
            results();
        end
    endtask : wait_irq

    task wait_ready;
        int k;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_in);
            if (hreadyout_out === 1'b1) break;
        end
        if (hreadyout_out !== 1'b1) begin
            errors++;
            $display("ERROR %0t: bus wait timed out", $time);
            results();
        end
    endtask : wait_ready

    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_in);
        hsel_in <= 1'b1;
        haddr_in <= a;
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        wait_ready();
        htrans_in <= 2'h0;
        hwdata_in <= d;
        wait_ready();
        q = hrdata_out;
        hsel_in <= 1'b0;
    endtask : ahb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask : wr

    task rd_cmp(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0000_0000, q);
        cmp32(q, exp);
    endtask : rd_cmp

    initial begin
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd_cmp(ofs[i], rst[i]);
            wr(ofs[i], 32'hffff_ffff);
            rd_cmp(ofs[i], full[i]);
            // Restore reset values; a divider of zero would break the tick spacing
            wr(ofs[i], rst[i]);
        end
        wr(8'h04, 32'hffff_ffff);
        rd_cmp(8'h04, 32'h0000_0000);
        wr(OFS_ELEM_UNIT_CONTROL, 32'h0000_0005);
        wr(OFS_EXTRA_GUARD_TIME, 32'h0000_0002);
        for (n = 0; n < 20 && etu_tick_out !== 1'b1; n++) @(posedge clk_in);
        @(posedge clk_in);
        for (n = 1; n < 20 && etu_tick_out !== 1'b1; n++) @(posedge clk_in);
        cmp32(32'(n), 32'h0000_0006);
        @(posedge clk_in);
        tx_char_done_in <= 1'b1;
        @(posedge clk_in);
        tx_char_done_in <= 1'b0;
        @(posedge clk_in);
        for (n = 0; n < 40 && tx_guard_hold_out === 1'b1; n++) @(posedge clk_in);
        cmp1(n > 6 && n <= 13, 1'b1);
        for (int i = 0; i < 8; i++) begin
            s = src[i];
            @(posedge clk_in);
            ev <= 11'(1) << s;
            @(posedge clk_in);
            ev <= '0;
            repeat (4) @(posedge clk_in);
            cmp1(irq_out, 1'b0);
            rd_cmp(OFS_IRQ_STATUS, 32'(1) << s);
            wr(OFS_IRQ_ENABLE_MASK, 32'(1) << s);
            wait_irq(1'b1);
            wr(OFS_IRQ_STATUS, 32'(1) << s);
            wait_irq(1'b0);
            wr(OFS_IRQ_ENABLE_MASK, 32'h0000_0000);
        end
        wr(OFS_IRQ_ENABLE_MASK, 32'h0000_0180);
        for (int p = 1; p >= 0; p--) begin
            u_card.set_pin(p[0]);
            wait_irq(1'b1);
            rd_cmp(OFS_IRQ_STATUS, {15'h0000, p[0], 16'h0080});
            wr(OFS_IRQ_STATUS, 32'h0000_0080);
            wait_irq(1'b0);
        end
        for (int q = 0; q < 3; q++) begin
            wr(OFS_SEQ_CONTROL, 32'(1) << q);
            @(negedge clk_in);
            cmp32(32'(seq_go), 32'(1) << q);
            wait_irq(1'b1);
            cmp32(32'(seq_go), 32'h0000_0000);
            wr(OFS_IRQ_STATUS, 32'h0000_0100);
            wait_irq(1'b0);
        end
        wr(OFS_IRQ_ENABLE_MASK, 32'h0000_0200);
        wr(OFS_RX_IDLE_TIMEOUT, 32'h0000_0002);
        u_card.send_char();
        repeat (12) @(posedge clk_in);
        cmp1(irq_out, 1'b0);
        wait_irq(1'b1);
        wr(OFS_IRQ_ENABLE_MASK, 32'h0000_0000);
        wait_irq(1'b0);
        rd_cmp(OFS_IRQ_STATUS, 32'h0000_0200);
        wr(OFS_IRQ_STATUS, 32'h0000_0200);
        wr(OFS_IRQ_ENABLE_MASK, 32'h0000_0200);
        u_card.send_char();
        repeat (8) @(posedge clk_in);
        u_card.send_char();
        repeat (12) @(posedge clk_in);
        cmp1(irq_out, 1'b0);
        wait_irq(1'b1);
        wr(OFS_IRQ_STATUS, 32'h0000_0200);
        u_card.send_char();
        repeat (5) @(posedge clk_in);
        rx_byte_read_in <= 1'b1;
        @(posedge clk_in);
        rx_byte_read_in <= 1'b0;
        repeat (40) @(posedge clk_in);
        cmp1(irq_out, 1'b0);
        u_card.send_char();
        wr(OFS_RX_IDLE_TIMEOUT, 32'h0000_0000);
        repeat (40) @(posedge clk_in);
        u_card.send_char();
        repeat (40) @(posedge clk_in);
        rd_cmp(OFS_IRQ_STATUS, 32'h0000_0000);
        results();
    end
endmodule : tb_sc_timing_top
